// [shared/apm_params.svh]
// Offsets, bit positions, reset values and timing figures of the audio power control.
`ifndef APM_PARAMS_SVH
`define APM_PARAMS_SVH

// ****************************************
// Register location
// ****************************************
`define APM_CTRL_PAGE     2'h2
`define APM_CTRL_ADDR     6'h05
`define APM_CTRL_RESET    16'hffc0
`define APM_CTRL_WMASK    16'hff7b

// ****************************************
// Field positions
// ****************************************
`define APM_BIT_MASTER    15
`define APM_BIT_REF_AUTO  14
`define APM_BIT_BYPASS    13
`define APM_BIT_HP_AMP    12
`define APM_BIT_MONO      11
`define APM_BIT_DAC       10
`define APM_BIT_ADC_L     9
`define APM_BIT_ADC_R     8
`define APM_BIT_SEQ_DONE  7
`define APM_BIT_MIC_BIAS  6
`define APM_BIT_OSC       5
`define APM_BIT_CLK_BUF   4
`define APM_BIT_SYNC_MON  3
`define APM_BIT_LOST_SYNC 2
`define APM_BIT_EFFECTS   1
`define APM_BIT_DEEMPH    0

// ****************************************
// Timing
// ****************************************
`define APM_CLK_MHZ       20
`define APM_VCM_START_US  500
`define APM_SETTLE_US     10

`endif

// [shared/apm_pkg.sv]
// Types shared by the audio power control design.
package apm_pkg;

	typedef logic [15:0] apm_word_t;

	// ****************************************
	// Register request from the serial control port
	// ****************************************
	typedef struct packed {
		logic      wr;
		logic      rd;
		logic [1:0] page;
		logic [5:0] addr;
		apm_word_t wdata;
	} apm_req_s;

	// ****************************************
	// Power enables, high means powered or on
	// ****************************************
	typedef struct packed {
		logic common_mode_reference;
		logic bypass_path;
		logic headphone_amp;
		logic mono_driver;
		logic stereo_dac;
		logic left_adc;
		logic right_adc;
		logic line_inputs;
		logic mic_preamp;
		logic left_mux;
		logic right_mux;
		logic left_volume;
		logic right_volume;
		logic mic_bias;
		logic osc_on;
		logic osc_clock_buffer_on;
		logic sync_monitor_on;
		logic effects_filter_on;
		logic deemphasis_on;
	} apm_pwr_s;

	// ****************************************
	// Module state
	// ****************************************
	typedef struct packed {
		apm_word_t ctrl;
		logic      audio_bus_lost_sync;
		logic      ref_hold;
		apm_pwr_s  pwr;
		apm_word_t rd_data;
		logic      rd_valid;
	} apm_state_s;

	typedef struct packed {
		apm_word_t count;
	} apm_timer_s;

	typedef struct packed {
		logic [1:0] stage;
	} apm_rst_s;

endpackage : apm_pkg

// [hdl/apm_rst_sync.sv]
// Reset release synchroniser for the audio power control.
`timescale 1ns/10ps

module apm_rst_sync (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	output logic      rst_n_sync
);

	apm_pkg::apm_rst_s st;
	apm_pkg::apm_rst_s nx;

	// Not gated by the clock enable, so reset always releases.
	always_comb begin
		nx = st;
		nx.stage = {st.stage[0], 1'b1};
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign rst_n_sync = st.stage[1];

endmodule : apm_rst_sync

// [hdl/apm_seq_timer.sv]
// Power sequencing settle timer.
`timescale 1ns/10ps

module apm_seq_timer (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic              ce,
	input  wire logic              load,
	input  apm_pkg::apm_word_t     load_val,
	output logic                   busy
);

	apm_pkg::apm_timer_s st;
	apm_pkg::apm_timer_s nx;

	// A new request never shortens a wait already running, so a slow
	// reference start is not cut short by a later quick change.
	always_comb begin
		nx = st;
		if (ce) begin
			if (load) begin
				nx.count = (load_val > st.count) ? load_val : st.count;
			end else if (st.count != 16'h0000) begin
				nx.count = 16'(st.count - 16'h0001);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign busy = (st.count != 16'h0000);

	property p_load_busy;
		@(posedge clk_sys) disable iff (!rst_n)
		ce && load && (load_val != 16'h0000) |=> busy;
	endproperty
	a_load_busy: assert property (p_load_busy) else $error("Timer idle after load.");

	property p_count_down;
		@(posedge clk_sys) disable iff (!rst_n)
		ce && !load && busy |=> st.count == 16'($past(st.count) - 16'h0001);
	endproperty
	a_count_down: assert property (p_count_down) else $error("Timer did not count down.");

endmodule : apm_seq_timer

// [hdl/apm_power_ctrl.sv]
// Audio power and miscellaneous control register with power sequencing.
`timescale 1ns/10ps
`include "apm_params.svh"

// How it works
// - Master off powers down every audio section.
// - Master bit never alters other stored bits.
// - Bits 15 and 13 to 8: one off, zero on.
// - Auto mode: reference follows ADC, DAC, bypass.
// - Hold mode: reference stays on once started, until master off.
// - Bit 13 controls the bypass path.
// - Bit 12 controls the headphone amplifier.
// - Mono on powers inputs, preamp, left chain.
// - Bit 10 controls the whole stereo DAC.
// - Left ADC on powers inputs and left chain.
// - Right ADC on powers inputs, right chain.
// - Audio power bits reset to one.
// - Bit 7 reads one when sequencing finished.
// - Bit 6 zero turns microphone bias on.
// - Bit 5 one turns the oscillator on.
// - Bit 4 one enables oscillator clock buffer.
// - Bit 3 zero enables the sync monitor.
// - Sticky lost-sync flag clears on read unless a loss comes in that cycle.
// - Bit 1 one enables the effects filter.
// - Bit 0 one enables de-emphasis.
module apm_power_ctrl #(
	parameter int VCM_START_CYCLES = `APM_VCM_START_US * `APM_CLK_MHZ,
	parameter int SETTLE_CYCLES    = `APM_SETTLE_US * `APM_CLK_MHZ
) (
	input  wire logic          clk_sys,
	input  wire logic          reset_n,
	input  wire logic          ce,
	input  apm_pkg::apm_req_s  reg_req,
	output apm_pkg::apm_word_t reg_rdata,
	output logic               reg_rvalid,
	input  wire logic          sync_loss_evt,
	output apm_pkg::apm_pwr_s  pwr_en,
	output logic               power_seq_done
);

	// ****************************************
	// Elaboration checks
	// ****************************************
	if (VCM_START_CYCLES < 1 || VCM_START_CYCLES > 65535) begin : g_bad_vcm
		$error("VCM_START_CYCLES must lie in 1 to 65535.");
	end
	if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_bad_settle
		$error("SETTLE_CYCLES must lie in 1 to 65535.");
	end

	localparam apm_pkg::apm_word_t VCM_LOAD    = apm_pkg::apm_word_t'(VCM_START_CYCLES);
	localparam apm_pkg::apm_word_t SETTLE_LOAD = apm_pkg::apm_word_t'(SETTLE_CYCLES);
	localparam apm_pkg::apm_word_t CTRL_INIT   = `APM_CTRL_RESET & `APM_CTRL_WMASK;

	logic                  rst_n_sync;
	apm_pkg::apm_state_s   st;
	apm_pkg::apm_state_s   nx;
	logic                  hit;
	logic                  wr_hit;
	logic                  rd_hit;
	logic                  evt_gated;
	logic                  audio_on;
	logic                  need_ref;
	logic                  timer_load;
	apm_pkg::apm_word_t    timer_val;
	logic                  timer_busy;
	apm_pkg::apm_word_t    status_word;

	// ****************************************
	// Reset release and settle timer
	// ****************************************
	apm_rst_sync u_rst (
		.clk_sys    (clk_sys),
		.reset_n    (reset_n),
		.rst_n_sync (rst_n_sync)
	);

	apm_seq_timer u_timer (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n_sync),
		.ce       (ce),
		.load     (timer_load),
		.load_val (timer_val),
		.busy     (timer_busy)
	);

	// ****************************************
	// Register decode
	// ****************************************
	assign hit    = (reg_req.page == `APM_CTRL_PAGE) && (reg_req.addr == `APM_CTRL_ADDR);
	assign wr_hit = reg_req.wr && hit;
	assign rd_hit = reg_req.rd && hit;

	// The monitor only reports while it is enabled.
	assign evt_gated = sync_loss_evt && !st.ctrl[`APM_BIT_SYNC_MON];

	assign status_word = {st.ctrl[15:8], !timer_busy, st.ctrl[6:3],
		st.audio_bus_lost_sync, st.ctrl[1:0]};

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		nx         = st;
		audio_on   = !st.ctrl[`APM_BIT_MASTER];
		need_ref   = 1'b0;
		timer_load = 1'b0;
		timer_val  = SETTLE_LOAD;
		if (ce) begin
			if (wr_hit) begin
				// Status positions are dropped, so stored copies stay zero.
				nx.ctrl = reg_req.wdata & `APM_CTRL_WMASK;
			end
			// A loss seen in the cycle of the read survives the clear.
			if (evt_gated) begin
				nx.audio_bus_lost_sync = 1'b1;
			end else if (rd_hit) begin
				nx.audio_bus_lost_sync = 1'b0;
			end
			nx.rd_valid = reg_req.rd;
			nx.rd_data  = rd_hit ? status_word : 16'h0000;

			// Master off overrides each section but leaves its bit alone.
			nx.pwr.bypass_path   = audio_on && !st.ctrl[`APM_BIT_BYPASS];
			nx.pwr.headphone_amp = audio_on && !st.ctrl[`APM_BIT_HP_AMP];
			nx.pwr.mono_driver   = audio_on && !st.ctrl[`APM_BIT_MONO];
			nx.pwr.stereo_dac    = audio_on && !st.ctrl[`APM_BIT_DAC];
			nx.pwr.left_adc      = audio_on && !st.ctrl[`APM_BIT_ADC_L];
			nx.pwr.right_adc     = audio_on && !st.ctrl[`APM_BIT_ADC_R];
			nx.pwr.mic_bias      = audio_on && !st.ctrl[`APM_BIT_MIC_BIAS];

			nx.pwr.line_inputs  = nx.pwr.mono_driver || nx.pwr.left_adc || nx.pwr.right_adc;
			nx.pwr.mic_preamp   = nx.pwr.line_inputs;
			nx.pwr.left_mux     = nx.pwr.mono_driver || nx.pwr.left_adc;
			nx.pwr.left_volume  = nx.pwr.left_mux;
			nx.pwr.right_mux    = nx.pwr.right_adc;
			nx.pwr.right_volume = nx.pwr.right_adc;

			need_ref = nx.pwr.bypass_path || nx.pwr.stereo_dac || nx.pwr.left_adc || nx.pwr.right_adc;
			// Holding the reference avoids its slow start on the next use.
			// A reference already running when hold mode starts is kept as well.
			nx.ref_hold = audio_on && !st.ctrl[`APM_BIT_REF_AUTO]
				&& (st.ref_hold || need_ref || st.pwr.common_mode_reference);
			nx.pwr.common_mode_reference = need_ref || nx.ref_hold;

			// Clock and processing controls are not audio sections.
			nx.pwr.osc_on              = st.ctrl[`APM_BIT_OSC];
			nx.pwr.osc_clock_buffer_on = st.ctrl[`APM_BIT_CLK_BUF];
			nx.pwr.sync_monitor_on     = !st.ctrl[`APM_BIT_SYNC_MON];
			nx.pwr.effects_filter_on   = st.ctrl[`APM_BIT_EFFECTS];
			nx.pwr.deemphasis_on       = st.ctrl[`APM_BIT_DEEMPH];

			timer_load = (nx.pwr != st.pwr);
			if (nx.pwr.common_mode_reference && !st.pwr.common_mode_reference) begin
				timer_val = VCM_LOAD;
			end
			// A change about to load the timer already reads as unfinished.
			nx.rd_data[`APM_BIT_SEQ_DONE] = rd_hit && !timer_busy && !timer_load;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			st                     <= '0;
			st.ctrl                <= CTRL_INIT;
			st.pwr.sync_monitor_on <= 1'b1;
		end else begin
			st <= nx;
		end
	end

	assign reg_rdata      = st.rd_data;
	assign reg_rvalid     = st.rd_valid;
	assign pwr_en         = st.pwr;
	assign power_seq_done = !timer_busy;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_loss;
		ce && evt_gated;
	endsequence

	sequence s_clean_read;
		ce && rd_hit && !evt_gated;
	endsequence

	property p_master_off;
		@(posedge clk_sys) disable iff (!rst_n_sync)
		ce && st.ctrl[`APM_BIT_MASTER] |=> (pwr_en.common_mode_reference == 1'b0) && (pwr_en.bypass_path == 1'b0)
			&& (pwr_en.headphone_amp == 1'b0) && (pwr_en.mono_driver == 1'b0) && (pwr_en.stereo_dac == 1'b0)
			&& (pwr_en.line_inputs == 1'b0) && (pwr_en.mic_bias == 1'b0) && (pwr_en.right_adc == 1'b0);
	endproperty
	a_master_off: assert property (p_master_off) else $error("Section powered under master off.");

	property p_ctrl_stable;
		@(posedge clk_sys) disable iff (!rst_n_sync)
		!(ce && wr_hit) |=> st.ctrl == $past(st.ctrl);
	endproperty
	a_ctrl_stable: assert property (p_ctrl_stable) else $error("Control changed without a write.");

	property p_write_store;
		@(posedge clk_sys) disable iff (!rst_n_sync)
		ce && wr_hit |=> st.ctrl == ($past(reg_req.wdata) & `APM_CTRL_WMASK);
	endproperty
	a_write_store: assert property (p_write_store) else $error("Write not stored.");

	property p_dac_follow;
		@(posedge clk_sys) disable iff (!rst_n_sync)
		ce |=> pwr_en.stereo_dac == !($past(st.ctrl[`APM_BIT_MASTER]) || $past(st.ctrl[`APM_BIT_DAC]));
	endproperty
	a_dac_follow: assert property (p_dac_follow) else $error("DAC enable wrong.");

	property p_hp_bypass;
		@(posedge clk_sys) disable iff (!rst_n_sync)
		ce && !st.ctrl[`APM_BIT_MASTER] |=> (pwr_en.headphone_amp == !$past(st.ctrl[`APM_BIT_HP_AMP]))
			&& (pwr_en.bypass_path == !$past(st.ctrl[`APM_BIT_BYPASS]));
	endproperty
	a_hp_bypass: assert property (p_hp_bypass) else $error("Headphone or bypass enable wrong.");

	property p_left_chain;
		@(posedge clk_sys) disable iff (!rst_n_sync)
		pwr_en.mono_driver || pwr_en.left_adc |-> pwr_en.line_inputs && pwr_en.mic_preamp
			&& pwr_en.left_mux && pwr_en.left_volume;
	endproperty
	a_left_chain: assert property (p_left_chain) else $error("Left input chain not powered.");

	property p_right_chain;
		@(posedge clk_sys) disable iff (!rst_n_sync)
		pwr_en.right_adc |-> pwr_en.line_inputs && pwr_en.mic_preamp && pwr_en.right_mux && pwr_en.right_volume;
	endproperty
	a_right_chain: assert property (p_right_chain) else $error("Right input chain not powered.");

	property p_ref_auto;
		@(posedge clk_sys) disable iff (!rst_n_sync)
		ce && st.ctrl[`APM_BIT_REF_AUTO] |=> pwr_en.common_mode_reference == (pwr_en.bypass_path
			|| pwr_en.stereo_dac || pwr_en.left_adc || pwr_en.right_adc);
	endproperty
	a_ref_auto: assert property (p_ref_auto) else $error("Reference not following its users.");

	property p_ref_hold;
		@(posedge clk_sys) disable iff (!rst_n_sync)
		ce && pwr_en.common_mode_reference && !st.ctrl[`APM_BIT_REF_AUTO] && !st.ctrl[`APM_BIT_MASTER]
			|=> pwr_en.common_mode_reference;
	endproperty
	a_ref_hold: assert property (p_ref_hold) else $error("Held reference dropped.");

	property p_seq_busy;
		@(posedge clk_sys) disable iff (!rst_n_sync)
		ce && timer_load |=> !power_seq_done;
	endproperty
	a_seq_busy: assert property (p_seq_busy) else $error("Done flag high during sequencing.");

	property p_misc_bits;
		@(posedge clk_sys) disable iff (!rst_n_sync)
		ce |=> (pwr_en.osc_on == $past(st.ctrl[`APM_BIT_OSC]))
			&& (pwr_en.osc_clock_buffer_on == $past(st.ctrl[`APM_BIT_CLK_BUF]))
			&& (pwr_en.effects_filter_on == $past(st.ctrl[`APM_BIT_EFFECTS]))
			&& (pwr_en.deemphasis_on == $past(st.ctrl[`APM_BIT_DEEMPH]));
	endproperty
	a_misc_bits: assert property (p_misc_bits) else $error("Clock or filter control wrong.");

	property p_sticky_cycle;
		@(posedge clk_sys) disable iff (!rst_n_sync)
		s_loss ##1 s_clean_read |=> !st.audio_bus_lost_sync && reg_rdata[`APM_BIT_LOST_SYNC];
	endproperty
	a_sticky_cycle: assert property (p_sticky_cycle) else $error("Lost-sync flag not reported and cleared.");

	property p_sticky_set;
		@(posedge clk_sys) disable iff (!rst_n_sync)
		s_loss |=> st.audio_bus_lost_sync;
	endproperty
	a_sticky_set: assert property (p_sticky_set) else $error("Lost-sync event dropped.");

	property p_write_no_flag;
		@(posedge clk_sys) disable iff (!rst_n_sync)
		ce && wr_hit && !rd_hit && !evt_gated |=> st.audio_bus_lost_sync == $past(st.audio_bus_lost_sync);
	endproperty
	a_write_no_flag: assert property (p_write_no_flag) else $error("Write altered lost-sync flag.");

	property p_mic_bias;
		@(posedge clk_sys) disable iff (!rst_n_sync)
		ce && !st.ctrl[`APM_BIT_MASTER] |=> pwr_en.mic_bias == !$past(st.ctrl[`APM_BIT_MIC_BIAS]);
	endproperty
	a_mic_bias: assert property (p_mic_bias) else $error("Microphone bias wrong.");

endmodule : apm_power_ctrl

// [verif/apm_host.sv]
// Host model that reaches the audio power control register over the register port.
`timescale 1ns/10ps
`include "apm_params.svh"

module apm_host (
	input  wire logic          clk_sys,
	output apm_pkg::apm_req_s  reg_req,
	input  apm_pkg::apm_word_t reg_rdata,
	input  wire logic          reg_rvalid
);
	// ****************************************
	// Register requests
	// ****************************************
	// Released address lines carry the inverse of the last value (page and data too after a write), so a design that samples late sees garbage.
	initial begin
		reg_req = '0;
	end

	task automatic wr(input logic [5:0] addr, input apm_pkg::apm_word_t data);
		@(negedge clk_sys);
		reg_req = '{wr: 1'b1, rd: 1'b0, page: `APM_CTRL_PAGE, addr: addr, wdata: data};
		@(negedge clk_sys);
		reg_req = '{wr: 1'b0, rd: 1'b0, page: ~`APM_CTRL_PAGE, addr: ~addr, wdata: ~data};
	endtask : wr

	task automatic rd(input logic [5:0] addr, output apm_pkg::apm_word_t data, output logic ok);
		@(negedge clk_sys);
		reg_req = '{wr: 1'b0, rd: 1'b1, page: `APM_CTRL_PAGE, addr: addr, wdata: 16'h0000};
		ok = 1'b0;
		data = '0;
		for (int n = 0; n < 4 && !ok; n++) begin
			@(negedge clk_sys);
			reg_req.rd = 1'b0;
			reg_req.addr = ~addr;
			if (reg_rvalid === 1'b1) begin
				ok = 1'b1;
				data = reg_rdata;
			end
		end
	endtask : rd

	// Sections just powered up are not used until the done flag reads one.
	task automatic poll_done(output logic ok);
		apm_pkg::apm_word_t d;
		logic               v;
		ok = 1'b0;
		for (int i = 0; i < 200 && !ok; i++) begin
			rd(`APM_CTRL_ADDR, d, v);
			ok = v & d[`APM_BIT_SEQ_DONE];
		end
	endtask : poll_done
endmodule : apm_host

// [verif/tb_top.sv]
// Self-checking testbench of the audio power control register.
`timescale 1ns/10ps
`include "apm_params.svh"

module tb_top;
	logic               clk_sys;
	logic               reset_n;
	logic               ce;
	logic               sync_loss_evt;
	apm_pkg::apm_req_s  reg_req;
	apm_pkg::apm_word_t reg_rdata;
	logic               reg_rvalid;
	apm_pkg::apm_pwr_s  pwr_en;
	logic               power_seq_done;
	int                 fails;
	int                 cmp_count;
	logic               ref_held;
	logic [15:0]        shadow;

	initial clk_sys = 1'b0;
	always #25 clk_sys = ~clk_sys;

	// ****************************************
	// Design and host
	// ****************************************
	// Short counts keep the run brief; the busy check and the 200-read done poll rely on them.
	apm_power_ctrl #(.VCM_START_CYCLES(20), .SETTLE_CYCLES(4)) i_apm_power_ctrl (
		.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .sync_loss_evt(sync_loss_evt), .pwr_en(pwr_en),
		.power_seq_done(power_seq_done));
	apm_host i_apm_host (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

	// ****************************************
	// Checking helpers
	// ****************************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	function automatic apm_pkg::apm_pwr_s model_pwr(input logic [15:0] c);
		apm_pkg::apm_pwr_s p;
		logic              on;
		logic              need;
		on = ~c[15];
		need = ~c[13] | ~c[10] | ~c[9] | ~c[8];
		p.common_mode_reference = on & (need | (~c[14] & ref_held));
		ref_held = p.common_mode_reference;
		p.bypass_path = on & ~c[13];
		p.headphone_amp = on & ~c[12];
		p.mono_driver = on & ~c[11];
		p.stereo_dac = on & ~c[10];
		p.left_adc = on & ~c[9];
		p.right_adc = on & ~c[8];
		p.line_inputs = p.mono_driver | p.left_adc | p.right_adc;
		p.mic_preamp = p.line_inputs;
		p.left_mux = p.mono_driver | p.left_adc;
		p.left_volume = p.left_mux;
		p.right_mux = p.right_adc;
		p.right_volume = p.right_adc;
		p.mic_bias = on & ~c[6];
		p.osc_on = c[5];
		p.osc_clock_buffer_on = c[4];
		p.sync_monitor_on = ~c[3];
		p.effects_filter_on = c[1];
		p.deemphasis_on = c[0];
		return p;
	endfunction : model_pwr

	task automatic read_expect(input string what, input logic [5:0] addr, input logic [15:0] exp);
		apm_pkg::apm_word_t d;
		logic               ok;
		i_apm_host.rd(addr, d, ok);
		check(what, {15'h0, ok, d}, {15'h0, 1'b1, exp});
	endtask : read_expect

	task automatic write_and_check(input logic [15:0] w, input logic busy_chk);
		logic              ok;
		apm_pkg::apm_pwr_s p;
		i_apm_host.wr(`APM_CTRL_ADDR, w);
		shadow = w & `APM_CTRL_WMASK;
		p = model_pwr(shadow);
		if (busy_chk) begin
			repeat (3) @(posedge clk_sys);
			#1;
			check("done low", {31'h0, power_seq_done}, 32'h0000_0000);
			read_expect("busy read", `APM_CTRL_ADDR, shadow);
		end
		i_apm_host.poll_done(ok);
		check("done poll", {31'h0, ok}, 32'h0000_0001);
		check("pwr_en", {13'h0, pwr_en}, {13'h0, p});
		read_expect("readback", `APM_CTRL_ADDR, shadow | 16'h0080);
	endtask : write_and_check

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_reset();
		check("reset pwr", {13'h0, pwr_en}, {13'h0, model_pwr(16'hffc0)});
		check("reset done", {31'h0, power_seq_done}, 32'h0000_0001);
		read_expect("reset value", `APM_CTRL_ADDR, 16'hffc0);
		$display("test reset done");
	endtask : test_reset

	task automatic test_sections();
		logic [15:0] tbl [6] = '{16'h7700, 16'h7d00, 16'h7e33, 16'h5b00, 16'h6f48, 16'h4fff};
		foreach (tbl[i]) write_and_check(tbl[i], 1'b0);
		$display("test sections done");
	endtask : test_sections

	task automatic test_master();
		write_and_check(16'h0033, 1'b0);
		write_and_check(16'h8033, 1'b0);
		write_and_check(16'h0033, 1'b0);
		$display("test master done");
	endtask : test_master

	task automatic test_hold();
		write_and_check(16'h3bff, 1'b0);
		write_and_check(16'h3fff, 1'b0);
		write_and_check(16'h7fff, 1'b0);
		write_and_check(16'h7bff, 1'b1);
		$display("test hold done");
	endtask : test_hold

	task automatic pulse_sync();
		@(negedge clk_sys);
		sync_loss_evt = 1'b1;
		@(negedge clk_sys);
		sync_loss_evt = 1'b0;
	endtask : pulse_sync

	task automatic test_sync();
		pulse_sync();
		read_expect("monitor off", `APM_CTRL_ADDR, shadow | 16'h0080);
		write_and_check(16'h7bf3, 1'b0);
		pulse_sync();
		read_expect("sticky set", `APM_CTRL_ADDR, shadow | 16'h0084);
		read_expect("sticky clear", `APM_CTRL_ADDR, shadow | 16'h0080);
		fork
			pulse_sync();
			read_expect("set wins read", `APM_CTRL_ADDR, shadow | 16'h0080);
		join
		read_expect("set wins kept", `APM_CTRL_ADDR, shadow | 16'h0084);
		fork
			pulse_sync();
			begin
				@(negedge clk_sys);
				read_expect("next cycle read", `APM_CTRL_ADDR, shadow | 16'h0084);
			end
		join
		read_expect("next cycle clear", `APM_CTRL_ADDR, shadow | 16'h0080);
		$display("test sync done");
	endtask : test_sync

	task automatic test_unmapped();
		read_expect("unmapped read", 6'h06, 16'h0000);
		i_apm_host.wr(6'h06, 16'h0000);
		read_expect("unmapped write", `APM_CTRL_ADDR, shadow | 16'h0080);
		$display("test unmapped done");
	endtask : test_unmapped

	task automatic test_freeze();
		@(negedge clk_sys);
		ce = 1'b0;
		i_apm_host.wr(`APM_CTRL_ADDR, 16'hffff);
		repeat (4) @(negedge clk_sys);
		check("frozen pwr", {13'h0, pwr_en}, {13'h0, model_pwr(shadow)});
		check("frozen done", {31'h0, power_seq_done}, 32'h0000_0001);
		ce = 1'b1;
		read_expect("frozen write", `APM_CTRL_ADDR, shadow | 16'h0080);
		$display("test freeze done");
	endtask : test_freeze

	// ****************************************
	// Verdict and sequence
	// ****************************************
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict

	initial begin
		#2_000_000;
		fails++;
		give_verdict();
	end

	initial begin
		reset_n = 1'b0;
		ce = 1'b1;
		sync_loss_evt = 1'b0;
		fails = 0;
		cmp_count = 0;
		ref_held = 1'b0;
		shadow = 16'hffc0;
		repeat (6) @(negedge clk_sys);
		reset_n = 1'b1;
		repeat (3) @(negedge clk_sys);
		test_reset();
		test_sections();
		test_master();
		test_hold();
		test_sync();
		test_unmapped();
		test_freeze();
		give_verdict();
	end
endmodule : tb_top
